// [include/otcs_params.svh]
// Function
// - six-bit tune loaded from factory value
// - software writes tune; larger means slower
// - config word two bit doubles rc
// - low power bit cleared on reset
// - half cpu clock out when crystal unused
// - rc select bit forces rc as cpu clock
// - watchdog oscillator has two rates
// - external mode: pin is port or clock
// - switch cpu clock source while running
// - read-only done flag in bit seven
// - done flag clears when switch starts
// - no control writes while done is zero
// - control source and doubler reset from config word one
// - decode three-bit oscillator type field
// - control bit three doubles rc
// - control bit four: crystal clocks watchdog
// - bit five picks 400k or 25k
// - only full resets reload the tune
`ifndef OTCS_PARAMS_SVH
`define OTCS_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OTCS_ADDR_TUNE 16'h0096
`define OTCS_ADDR_CTRL 16'hFFDE
`define OTCS_ADDR_AUX 16'h00A0

// ----------------------------------------
// field positions
// ----------------------------------------
`define OTCS_CFG1_DBL_BIT 7
`define OTCS_CFG2_DBL_BIT 7
`define OTCS_AUX_LP_BIT 7

// ----------------------------------------
// oscillator type codes
// ----------------------------------------
`define OTCS_OSC_EXT 3'h7
`define OTCS_OSC_WDT 3'h4
`define OTCS_OSC_RC 3'h3
`define OTCS_OSC_XLO 3'h2
`define OTCS_OSC_XMD 3'h1
`define OTCS_OSC_XHI 3'h0

// ----------------------------------------
// reset values
// ----------------------------------------
`define OTCS_RST_DONE 1'b1
`define OTCS_RST_HI3 3'h0
`define OTCS_RST_TSEL 2'h0
`define OTCS_RST_LP 1'b0

`endif

// [include/otcs_pkg.sv]
`default_nettype none
package otcs_pkg;

    // oscillator class decoded from the type field
    typedef enum logic [2:0] {
        OTCS_CLS_EXT,
        OTCS_CLS_WDT,
        OTCS_CLS_RC,
        OTCS_CLS_XTAL,
        OTCS_CLS_BAD
    } otcs_cls_e;

    // switch sequencer
    typedef enum logic [1:0] {
        OTCS_SW_IDLE,
        OTCS_SW_REQ,
        OTCS_SW_REL
    } otcs_sw_e;

    typedef struct packed {
        logic rc_sel;
        logic clk_out_en;
        logic [5:0] tune;
    } otcs_tune_s;

    typedef struct packed {
        logic done;
        logic rsv;
        logic wd_rate;
        logic xtal_wd;
        logic dbl;
        logic [2:0] osc;
    } otcs_ctrl_s;

endpackage
`default_nettype wire

// [core/otcs_top.sv]
// The implementer's own choice: the plain strobed port.
`include "otcs_params.svh"
`default_nettype none

module otcs_top
    import otcs_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST_N,
    // full reset cause: power-on or watchdog
    input wire logic FULL_RESET,
    input wire logic [5:0] FACTORY_TUNE,
    input wire logic [7:0] CFG_WORD_ONE,
    input wire logic [7:0] CFG_WORD_TWO,
    // register port
    input wire logic [15:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // clock mux handshake
    output logic SW_REQ,
    output logic [2:0] SW_SRC,
    input wire logic SW_ACK,
    // clock steering
    output logic [2:0] CPU_SRC,
    output logic RC_DOUBLE,
    output logic [5:0] RC_TUNE,
    output logic WDT_XTAL,
    output logic WDT_SLOW,
    output logic LOW_POWER,
    // crystal output pin
    input wire logic PORT_DATA,
    input wire logic PORT_OE,
    output logic XTAL_OUT_O,
    output logic XTAL_OUT_OE
);

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------

    // type field to oscillator class
    function automatic otcs_cls_e osc_class(input logic [2:0] code);
        otcs_cls_e c;
        c = OTCS_CLS_BAD;
        case (code)
            `OTCS_OSC_EXT: c = OTCS_CLS_EXT;
            `OTCS_OSC_WDT: c = OTCS_CLS_WDT;
            `OTCS_OSC_RC: c = OTCS_CLS_RC;
            `OTCS_OSC_XLO: c = OTCS_CLS_XTAL;
            `OTCS_OSC_XMD: c = OTCS_CLS_XTAL;
            `OTCS_OSC_XHI: c = OTCS_CLS_XTAL;
            default: c = OTCS_CLS_BAD;
        endcase
        return c;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    otcs_tune_s tune_q;
    otcs_tune_s tune_d;
    otcs_ctrl_s ctrl_q;
    otcs_ctrl_s ctrl_d;
    otcs_sw_e sw_q;
    otcs_sw_e sw_d;
    logic [2:0] act_src_q;
    logic [2:0] act_src_d;
    logic act_dbl_q;
    logic act_dbl_d;
    logic lp_q;
    logic lp_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic ack_meta_q;
    logic ack_sync_q;
    logic sw_req_q;
    logic [2:0] cpu_src_q;
    logic [2:0] cpu_src_d;
    logic rc_dbl_q;
    logic rc_dbl_d;
    logic wdt_xtal_q;
    logic wdt_slow_q;
    logic pin_o_q;
    logic pin_o_d;
    logic pin_oe_q;
    logic pin_oe_d;

    // ----------------------------------------
    // register port decode
    // ----------------------------------------
    otcs_ctrl_s wr_ctrl;
    wire sel_tune = (ADDR == `OTCS_ADDR_TUNE);
    wire sel_ctrl = (ADDR == `OTCS_ADDR_CTRL);
    wire sel_aux = (ADDR == `OTCS_ADDR_AUX);
    wire wr_tune = WR && sel_tune;
    wire wr_aux = WR && sel_aux;
    assign wr_ctrl = otcs_ctrl_s'(WDATA);

    // reserved codes are refused whole, like a locked write
    wire wr_code_ok = (osc_class(wr_ctrl.osc) != OTCS_CLS_BAD);
    wire wr_ctrl_ok = WR && sel_ctrl && ctrl_q.done && wr_code_ok;

    // a new source or doubler setting needs a changeover
    wire src_change = (wr_ctrl.osc != ctrl_q.osc) || (wr_ctrl.dbl != ctrl_q.dbl);
    wire sw_start = wr_ctrl_ok && src_change;

    // ----------------------------------------
    // tune register next value
    // ----------------------------------------
    // the whole byte is taken; keeping the tune intact
    // across bit six or seven edits is up to software
    assign tune_d = wr_tune ? otcs_tune_s'(WDATA) : tune_q;

    // ----------------------------------------
    // low power bit next value
    // ----------------------------------------
    assign lp_d = wr_aux ? WDATA[`OTCS_AUX_LP_BIT] : lp_q;

    // ----------------------------------------
    // switch sequencer
    // ----------------------------------------
    // the mux keeps the old clock until it has both
    // edges parked; ack high means the new one is live
    always_comb begin
        sw_d = sw_q;
        act_src_d = act_src_q;
        act_dbl_d = act_dbl_q;
        case (sw_q)
            OTCS_SW_IDLE: begin
                if (sw_start) begin
                    sw_d = OTCS_SW_REQ;
                end
            end
            OTCS_SW_REQ: begin
                if (ack_sync_q) begin
                    sw_d = OTCS_SW_REL;
                    act_src_d = ctrl_q.osc;
                    act_dbl_d = ctrl_q.dbl;
                end
            end
            OTCS_SW_REL: begin
                if (!ack_sync_q) begin
                    sw_d = OTCS_SW_IDLE;
                end
            end
            default: sw_d = OTCS_SW_IDLE;
        endcase
    end

    // ----------------------------------------
    // control register next value
    // ----------------------------------------
    // writes are only taken while done is high, so the
    // hardware set and the software start never collide
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl_ok) begin
            ctrl_d.osc = wr_ctrl.osc;
            ctrl_d.dbl = wr_ctrl.dbl;
            ctrl_d.xtal_wd = wr_ctrl.xtal_wd;
            ctrl_d.wd_rate = wr_ctrl.wd_rate;
        end
        if (sw_start) begin
            ctrl_d.done = 1'b0;
        end else if (sw_q == OTCS_SW_REL && !ack_sync_q) begin
            ctrl_d.done = 1'b1;
        end
        ctrl_d.rsv = 1'b0;
    end

    // ----------------------------------------
    // cpu clock steering
    // ----------------------------------------
    // rc select overrides the committed source at once
    assign cpu_src_d = tune_q.rc_sel ? `OTCS_OSC_RC : act_src_q;

    // either doubler source doubles the rc output
    wire dbl_any = CFG_WORD_TWO[`OTCS_CFG2_DBL_BIT] || act_dbl_q;
    assign rc_dbl_d = dbl_any && (osc_class(cpu_src_d) == OTCS_CLS_RC);

    // ----------------------------------------
    // watchdog clock choice
    // ----------------------------------------
    // rate only matters while the crystal does not clock the watchdog
    wire wdt_slow_d = !ctrl_q.xtal_wd && ctrl_q.wd_rate;

    // ----------------------------------------
    // crystal output pin
    // ----------------------------------------
    // the crystal is in use when it clocks the cpu or
    // the watchdog; then the pin belongs to the crystal
    wire xtal_used = (osc_class(cpu_src_d) == OTCS_CLS_XTAL) || ctrl_q.xtal_wd;
    wire clk_out_on = tune_q.clk_out_en && !xtal_used;

    // toggling every edge gives half of the cpu clock,
    // which the core clock stands in for here
    assign pin_o_d = clk_out_on ? !pin_o_q : PORT_DATA;
    assign pin_oe_d = clk_out_on || (!xtal_used && PORT_OE);

    // ----------------------------------------
    // read data
    // ----------------------------------------
    // unmapped reads answer zero; no read side effects
    always_comb begin
        rdata_d = 8'h00;
        if (RD && sel_tune) begin
            rdata_d = tune_q;
        end else if (RD && sel_ctrl) begin
            rdata_d = ctrl_q;
        end else if (RD && sel_aux) begin
            rdata_d[`OTCS_AUX_LP_BIT] = lp_q;
        end
    end

    // ----------------------------------------
    // ack synchroniser
    // ----------------------------------------
    // the mux runs on the oscillators, not on CLOCK
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            ack_meta_q <= 1'b0;
            ack_sync_q <= 1'b0;
        end else begin
            ack_meta_q <= SW_ACK;
            ack_sync_q <= ack_meta_q;
        end
    end

    // ----------------------------------------
    // tune register
    // ----------------------------------------
    // a light reset keeps the calibration the user set
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            tune_q.rc_sel <= 1'b0;
            tune_q.clk_out_en <= 1'b0;
            if (FULL_RESET) begin
                tune_q.tune <= FACTORY_TUNE;
            end
        end else begin
            tune_q <= tune_d;
        end
    end

    // ----------------------------------------
    // control register and sequencer
    // ----------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            ctrl_q.done <= `OTCS_RST_DONE;
            {ctrl_q.rsv, ctrl_q.wd_rate, ctrl_q.xtal_wd} <= `OTCS_RST_HI3;
            ctrl_q.dbl <= CFG_WORD_ONE[`OTCS_CFG1_DBL_BIT];
            ctrl_q.osc <= CFG_WORD_ONE[2:0];
            act_src_q <= CFG_WORD_ONE[2:0];
            act_dbl_q <= CFG_WORD_ONE[`OTCS_CFG1_DBL_BIT];
            sw_q <= OTCS_SW_IDLE;
            sw_req_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            act_src_q <= act_src_d;
            act_dbl_q <= act_dbl_d;
            sw_q <= sw_d;
            sw_req_q <= (sw_d == OTCS_SW_REQ);
        end
    end

    // ----------------------------------------
    // aux, read data and steering outputs
    // ----------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            lp_q <= `OTCS_RST_LP;
            rdata_q <= 8'h00;
            cpu_src_q <= CFG_WORD_ONE[2:0];
            rc_dbl_q <= 1'b0;
            {wdt_xtal_q, wdt_slow_q} <= `OTCS_RST_TSEL;
            pin_o_q <= 1'b0;
            pin_oe_q <= 1'b0;
        end else begin
            lp_q <= lp_d;
            rdata_q <= rdata_d;
            cpu_src_q <= cpu_src_d;
            rc_dbl_q <= rc_dbl_d;
            wdt_xtal_q <= ctrl_q.xtal_wd;
            wdt_slow_q <= wdt_slow_d;
            pin_o_q <= pin_o_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    // ----------------------------------------
    // output wiring
    // ----------------------------------------
    assign RDATA = rdata_q;
    assign SW_REQ = sw_req_q;
    assign SW_SRC = ctrl_q.osc;
    assign CPU_SRC = cpu_src_q;
    assign RC_DOUBLE = rc_dbl_q;
    assign RC_TUNE = tune_q.tune;
    assign WDT_XTAL = wdt_xtal_q;
    assign WDT_SLOW = wdt_slow_q;
    assign LOW_POWER = lp_q;
    assign XTAL_OUT_O = pin_o_q;
    assign XTAL_OUT_OE = pin_oe_q;

endmodule

`default_nettype wire

// [testbench/otcs_mux_model.sv]
`default_nettype none
// clock mux stand-in: follows the request level after a settable lag
module otcs_mux_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] lag,
    input wire logic sw_req,
    output logic sw_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q;
    // old clock stays live until the lag runs out, so slow muxes are covered too
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sw_ack <= 1'b0;
            cnt_q <= 4'h0;
        end else if (sw_req != sw_ack && cnt_q >= lag) begin
            sw_ack <= sw_req;
            cnt_q <= 4'h0;
        end else if (sw_req != sw_ack) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

// [testbench/otcs_monitor.sv]
`include "otcs_params.svh"
`default_nettype none
module otcs_monitor (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic [15:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic SW_REQ,
    input wire logic [2:0] SW_SRC,
    input wire logic SW_ACK,
    input wire logic [2:0] CPU_SRC,
    input wire logic [5:0] RC_TUNE,
    input wire logic WDT_XTAL,
    input wire logic WDT_SLOW,
    input wire logic LOW_POWER,
    input wire logic PORT_OE,
    input wire logic XTAL_OUT_O,
    input wire logic XTAL_OUT_OE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    // decoded write strobes
    wire wr_ctrl = WR && ADDR == `OTCS_ADDR_CTRL;
    wire wr_tune = WR && ADDR == `OTCS_ADDR_TUNE;
    wire wr_aux = WR && ADDR == `OTCS_ADDR_AUX;
    tune_write_a: assert property (wr_tune |=> RC_TUNE == $past(WDATA[5:0]))
        else $error("tune field did not take the write");
    low_power_a: assert property (wr_aux |=> LOW_POWER == $past(WDATA[7]))
        else $error("low power bit did not take the write");
    read_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data outside the answer cycle");
    rsv_bit_a: assert property (RD && ADDR == `OTCS_ADDR_CTRL |=> !RDATA[6])
        else $error("reserved control bit read as one");
    switch_src_a: assert property ($rose(SW_REQ) |-> $past(wr_ctrl) &&
        SW_SRC == $past(WDATA[2:0])) else $error("switch started without a control write");
    req_hold_a: assert property ($rose(SW_REQ) |-> SW_REQ [*3])
        else $error("changeover request dropped early");
    busy_lock_a: assert property (SW_REQ && wr_ctrl |=> SW_SRC == $past(SW_SRC))
        else $error("control write taken during a switch");
    ack_drop_a: assert property ($rose(SW_ACK) |-> ##[2:4] !SW_REQ)
        else $error("request not released after acknowledge");
    commit_a: assert property ($fell(SW_REQ) |=> CPU_SRC == SW_SRC || CPU_SRC == 3'h3)
        else $error("cpu source not committed");
    clk_out_a: assert property (XTAL_OUT_OE && $past(XTAL_OUT_OE) && !$past(PORT_OE) &&
        !$past(PORT_OE, 2) |-> XTAL_OUT_O != $past(XTAL_OUT_O))
        else $error("clock output not toggling");
    wdt_slow_a: assert property (WDT_SLOW |-> !WDT_XTAL)
        else $error("slow watchdog rate while crystal clocks watchdog");
endmodule
bind otcs_top otcs_monitor mon (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .SW_REQ(SW_REQ), .SW_SRC(SW_SRC), .SW_ACK(SW_ACK),
    .CPU_SRC(CPU_SRC), .RC_TUNE(RC_TUNE), .WDT_XTAL(WDT_XTAL), .WDT_SLOW(WDT_SLOW),
    .LOW_POWER(LOW_POWER), .PORT_OE(PORT_OE), .XTAL_OUT_O(XTAL_OUT_O),
    .XTAL_OUT_OE(XTAL_OUT_OE));
`default_nettype wire

// [testbench/osc_trim_and_clock_switch_tb.sv]
`include "otcs_params.svh"
`default_nettype none
module osc_trim_and_clock_switch_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst_n = 0, full_rst = 1, wr = 0, rd = 0, pdata = 0, poe = 0;
    logic [5:0] ftune = 6'h00, tune;
    // doubler set, so control bit three reads set after reset as well
    logic [7:0] cfg1 = 8'h88, cfg2 = 8'h00, wdata = 8'h00, rdata, d, v, o;
    logic [15:0] addr = 16'h0000;
    logic sw_req, sw_ack, rc_dbl, wxt, wsl, lp, xo, xoe;
    logic [2:0] sw_src, cpu_src;
    logic [5:0] rc_tune;
    logic [3:0] lag = 4'h0;
    logic [31:0] r;
    int err_count = 0, samples_checked = 0, seed = 32'h045c_0610;
    otcs_top dut (.CLOCK(clock), .RST_N(rst_n), .FULL_RESET(full_rst), .FACTORY_TUNE(ftune),
        .CFG_WORD_ONE(cfg1), .CFG_WORD_TWO(cfg2), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .SW_REQ(sw_req), .SW_SRC(sw_src), .SW_ACK(sw_ack),
        .CPU_SRC(cpu_src), .RC_DOUBLE(rc_dbl), .RC_TUNE(rc_tune), .WDT_XTAL(wxt),
        .WDT_SLOW(wsl), .LOW_POWER(lp), .PORT_DATA(pdata), .PORT_OE(poe),
        .XTAL_OUT_O(xo), .XTAL_OUT_OE(xoe));
    otcs_mux_model mux (.clk(clock), .rst_n(rst_n), .lag(lag), .sw_req(sw_req),
        .sw_ack(sw_ack));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // control readback: done set, reserved bit clear
    function automatic logic [7:0] ctrl_exp(input logic [7:0] w);
        return {2'b10, w[5:0]};
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] x);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= x;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] x);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1 x = rdata;
    endtask
    // start a switch, poke it while busy, then wait a bounded time for done
    task automatic switch_to(input logic [7:0] x);
        wr_reg(`OTCS_ADDR_CTRL, x);
        rd_reg(`OTCS_ADDR_CTRL, d);
        chk(d & 8'h80, 8'h00);
        wr_reg(`OTCS_ADDR_CTRL, x ^ 8'h01);
        for (int i = 0; i < 60 && !d[7]; i++)
            rd_reg(`OTCS_ADDR_CTRL, d);
        chk(d, ctrl_exp(x));
        chk({5'h00, cpu_src}, {5'h00, x[2:0]});
    endtask
    task automatic test_done;
        $display("checked %0d values, %0d wrong", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #(20000 * 40);
        err_count++;
        test_done();
    end
    initial begin
        r = $random(seed);
        ftune = r[5:0];
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        rd_reg(`OTCS_ADDR_TUNE, d);
        chk(d, {2'b00, ftune});
        rd_reg(`OTCS_ADDR_CTRL, d);
        chk(d, 8'h88);
        chk({5'h00, cpu_src}, {5'h00, cfg1[2:0]});
        $display("reset values done");
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            tune = r[5:0];
            wr_reg(`OTCS_ADDR_TUNE, {2'b00, tune});
            rd_reg(`OTCS_ADDR_TUNE, d);
            chk(d, {2'b00, tune});
            wr_reg(`OTCS_ADDR_AUX, {r[7], 7'h00});
            rd_reg(16'h1234, d);
            chk(d, 8'h00);
            chk({7'h00, lp}, {7'h00, r[7]});
        end
        // rewrite the held tune with bit seven set; rc select forces cpu source three
        wr_reg(`OTCS_ADDR_TUNE, {2'b10, tune});
        repeat (2) @(posedge clock);
        #1 chk({5'h00, cpu_src}, 8'h03);
        wr_reg(`OTCS_ADDR_TUNE, {2'b00, tune});
        $display("register access done");
        for (int i = 0; i < 6; i++) begin
            lag <= i[0] ? 4'h9 : 4'h0;
            v = {4'h0, i[0], 3'h0};
            v[2:0] = i == 0 ? 3'h7 : i == 1 ? 3'h4 : i == 5 ? 3'h3 : 3'(4 - i);
            switch_to(v);
        end
        wr_reg(`OTCS_ADDR_CTRL, 8'h05);
        rd_reg(`OTCS_ADDR_CTRL, d);
        chk(d, ctrl_exp(v));
        chk({7'h00, rc_dbl}, 8'h01);
        // drop the control doubler, then let config word two double alone
        v = 8'h03;
        switch_to(v);
        chk({7'h00, rc_dbl}, 8'h00);
        cfg2 <= 8'h80;
        repeat (2) @(posedge clock);
        #1 chk({7'h00, rc_dbl}, 8'h01);
        cfg2 <= 8'h00;
        wr_reg(`OTCS_ADDR_CTRL, v | 8'h20);
        repeat (2) @(posedge clock);
        #1 chk({6'h00, wxt, wsl}, 8'h01);
        wr_reg(`OTCS_ADDR_CTRL, v | 8'h30);
        repeat (2) @(posedge clock);
        #1 chk({6'h00, wxt, wsl}, 8'h02);
        wr_reg(`OTCS_ADDR_CTRL, v);
        $display("clock switching done");
        wr_reg(`OTCS_ADDR_TUNE, {2'b01, tune});
        repeat (3) @(posedge clock);
        // sample off the edge so the pin has settled
        #1 o[0] = xo;
        @(posedge clock);
        #1 chk({6'h00, xoe, xo}, {6'h01, ~o[0]});
        r = $random(seed);
        pdata <= r[0];
        poe <= 1'b1;
        wr_reg(`OTCS_ADDR_TUNE, {2'b00, tune});
        repeat (2) @(posedge clock);
        #1 chk({6'h00, xoe, xo}, {6'h01, r[0]});
        $display("clock output done");
        full_rst <= 1'b0;
        rst_n <= 1'b0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        rd_reg(`OTCS_ADDR_TUNE, d);
        chk(d, {2'b00, tune});
        chk({7'h00, lp}, 8'h00);
        $display("warm reset done");
        test_done();
    end
endmodule
`default_nettype wire
